// >>> hw/ivls_supervisor.sv
// input-voltage limit registers, warnings, undervoltage fault and retry
`include "ivls_consts.svh"
`timescale 1ns/100ps
module ivls_supervisor #(
  parameter int unsigned RETRY_CYCLES = `IVLS_RETRY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] vin_sample,
  input wire logic vin_valid,
  input wire logic [15:0] strap_uv_fault_limit,
  input wire logic run_request,
  input wire logic other_fault,
  output logic power_stage_enable,
  output logic host_alert_output_n
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // warning default kept in the fault limit's exponent; one renormalise step
  // covers the 10 % headroom, at the cost of the lowest mantissa bit
  function automatic logic [15:0] scale_warn(input logic [15:0] fault_lim);
    logic signed [15:0] mant;
    logic signed [4:0] expo;
    mant = 16'(signed'(fault_lim[`IVLS_MANT_HI:0]));
    expo = $signed(fault_lim[`IVLS_EXP_HI:`IVLS_EXP_LO]);
    mant = 16'((32'(mant) * `IVLS_UV_WARN_NUM) / `IVLS_UV_WARN_DEN);
    if (mant > 16'sd1023 || mant < -16'sd1024) begin
      mant = mant >>> 1;
      expo = expo + 5'sd1;
    end
    return {expo, mant[`IVLS_MANT_HI:0]};
  endfunction : scale_warn

  // one access strobe aimed at one command code
  function automatic logic is_cmd(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] code
  );
    return strobe && addr == code;
  endfunction : is_cmd

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [15:0] ov_warn_limit;
  logic [15:0] uv_warn_limit;
  logic [15:0] uv_fault_limit;
  logic [7:0] uv_fault_reaction;
  logic strap_loaded;
  logic [7:0] status_input;
  logic sw_input;
  logic sw_none_above;
  ivls_pkg::ivls_state_t state;
  ivls_pkg::ivls_state_t next_state;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // writes to status codes and unmapped codes fall through untouched
  wire wr_ov_warn = is_cmd(reg_wr, reg_addr, `IVLS_CMD_OV_WARN_LIMIT);
  wire wr_uv_warn = is_cmd(reg_wr, reg_addr, `IVLS_CMD_UV_WARN_LIMIT);
  wire wr_uv_fault = is_cmd(reg_wr, reg_addr, `IVLS_CMD_UV_FAULT_LIMIT);
  wire wr_reaction = is_cmd(reg_wr, reg_addr, `IVLS_CMD_UV_FAULT_REACTION);
  // any data written to the clear code clears; the data is ignored
  wire clear_faults = is_cmd(reg_wr, reg_addr, `IVLS_CMD_CLEAR_FAULTS);

  logic [15:0] read_mux;
  always_comb begin
    case (reg_addr)
      `IVLS_CMD_OV_WARN_LIMIT: read_mux = ov_warn_limit;
      `IVLS_CMD_UV_WARN_LIMIT: read_mux = uv_warn_limit;
      `IVLS_CMD_UV_FAULT_LIMIT: read_mux = uv_fault_limit;
      `IVLS_CMD_UV_FAULT_REACTION: read_mux = {8'h00, uv_fault_reaction};
      `IVLS_CMD_STATUS_INPUT: read_mux = {8'h00, status_input};
      `IVLS_CMD_STATUS_WORD: begin
        read_mux = 16'h0000;
        read_mux[`IVLS_SW_INPUT] = sw_input;
        read_mux[`IVLS_SW_NONE_ABOVE] = sw_none_above;
      end
      default: read_mux = 16'h0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // threshold comparison
  // --------------------------------------------------------------------------
  logic ov_warn_above;
  logic uv_warn_below;
  logic uv_fault_below;

  ivls_lin_compare u_cmp_ov_warn (
    .sample(vin_sample),
    .limit(ov_warn_limit),
    .above(ov_warn_above),
    .below()
  );

  ivls_lin_compare u_cmp_uv_warn (
    .sample(vin_sample),
    .limit(uv_warn_limit),
    .above(),
    .below(uv_warn_below)
  );

  ivls_lin_compare u_cmp_uv_fault (
    .sample(vin_sample),
    .limit(uv_fault_limit),
    .above(),
    .below(uv_fault_below)
  );

  // every valid sample is judged; the sticky bit records the first crossing
  wire set_ov_warn = vin_valid && ov_warn_above;
  wire set_uv_warn = vin_valid && uv_warn_below;
  wire set_uv_fault = vin_valid && uv_fault_below;
  wire set_any = set_ov_warn || set_uv_warn || set_uv_fault;

  // --------------------------------------------------------------------------
  // status flags; a set in the clearing cycle survives
  // --------------------------------------------------------------------------
  logic [7:0] status_set;
  always_comb begin
    status_set = 8'h00;
    status_set[`IVLS_SI_OV_WARN] = set_ov_warn;
    status_set[`IVLS_SI_UV_WARN] = set_uv_warn;
    status_set[`IVLS_SI_UV_FAULT] = set_uv_fault;
  end

  wire [7:0] next_status_input =
    (status_input & {8{~clear_faults}}) | status_set;
  wire next_sw_input = (sw_input && !clear_faults) || set_any;
  wire next_sw_none_above = (sw_none_above && !clear_faults) || set_any;

  // --------------------------------------------------------------------------
  // fault reaction
  // --------------------------------------------------------------------------
  wire [1:0] behaviour = uv_fault_reaction[`IVLS_BEHAV_HI:`IVLS_BEHAV_LO];
  wire [2:0] retry = uv_fault_reaction[`IVLS_RETRY_HI:`IVLS_RETRY_LO];
  // unused behaviour codes only flag and alert, they never shut down
  wire shut_on_fault = behaviour == `IVLS_BEHAV_DISABLE;
  // unused retry codes behave as no retry, the safer reading
  wire retry_forever = retry == `IVLS_RETRY_FOREVER;
  wire fault_event = set_uv_fault && shut_on_fault;
  logic retry_expired;

  always_comb begin
    next_state = state;
    case (state)
      ivls_pkg::ivls_st_off: begin
        if (run_request && !other_fault) begin
          next_state = ivls_pkg::ivls_st_run;
        end
      end
      ivls_pkg::ivls_st_run: begin
        if (!run_request || other_fault) begin
          next_state = ivls_pkg::ivls_st_off;
        end else if (fault_event && retry_forever) begin
          next_state = ivls_pkg::ivls_st_wait;
        end else if (fault_event) begin
          next_state = ivls_pkg::ivls_st_latched;
        end
      end
      ivls_pkg::ivls_st_latched: begin
        if (clear_faults) begin
          next_state = ivls_pkg::ivls_st_off;
        end
      end
      ivls_pkg::ivls_st_wait: begin
        if (!run_request || other_fault) begin
          next_state = ivls_pkg::ivls_st_off;
        end else if (retry_expired) begin
          next_state = ivls_pkg::ivls_st_run;
        end
      end
      default: next_state = ivls_pkg::ivls_st_off;
    endcase
  end

  wire enter_wait = state != ivls_pkg::ivls_st_wait &&
    next_state == ivls_pkg::ivls_st_wait;
  wire leave_wait = state == ivls_pkg::ivls_st_wait &&
    next_state != ivls_pkg::ivls_st_wait;

  // interval does not depend on the low reaction bits
  ivls_retry_timer #(
    .CYCLES(RETRY_CYCLES)
  ) u_retry_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(enter_wait),
    .cancel(leave_wait),
    .expired(retry_expired)
  );

  // --------------------------------------------------------------------------
  // register file and state
  // --------------------------------------------------------------------------
  // strap is taken on the first clock after reset, never under reset itself
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_loaded <= 1'b0;
    end else begin
      strap_loaded <= 1'b1;
    end
  end

  // the strap load owns the first cycle; a host write there is lost
  wire take_strap = !strap_loaded;
  wire host_wr_ok = strap_loaded;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ov_warn_limit <= `IVLS_OV_WARN_RESET;
    end else if (wr_ov_warn && host_wr_ok) begin
      ov_warn_limit <= reg_wdata;
    end
  end

  // warning default follows the strap, not a fixed constant
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uv_warn_limit <= 16'h0000;
    end else if (take_strap) begin
      uv_warn_limit <= scale_warn(strap_uv_fault_limit);
    end else if (wr_uv_warn) begin
      uv_warn_limit <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uv_fault_limit <= 16'h0000;
    end else if (take_strap) begin
      uv_fault_limit <= strap_uv_fault_limit;
    end else if (wr_uv_fault) begin
      uv_fault_limit <= reg_wdata;
    end
  end

  // one-byte register; the upper write byte is dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uv_fault_reaction <= `IVLS_UV_REACTION_RESET;
    end else if (wr_reaction && host_wr_ok) begin
      uv_fault_reaction <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_input <= 8'h00;
      sw_input <= 1'b0;
      sw_none_above <= 1'b0;
      host_alert_output_n <= 1'b1;
    end else begin
      status_input <= next_status_input;
      sw_input <= next_sw_input;
      sw_none_above <= next_sw_none_above;
      host_alert_output_n <= ~(|next_status_input);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ivls_pkg::ivls_st_off;
      power_stage_enable <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      state <= next_state;
      power_stage_enable <= next_state == ivls_pkg::ivls_st_run;
      if (reg_rd) reg_rdata <= read_mux;
    end
  end

endmodule : ivls_supervisor

// >>> hw/ivls_consts.svh
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef IVLS_CONSTS_SVH
`define IVLS_CONSTS_SVH

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define IVLS_CMD_CLEAR_FAULTS 8'h03
`define IVLS_CMD_STATUS_WORD 8'h79
`define IVLS_CMD_STATUS_INPUT 8'h7c
`define IVLS_CMD_OV_WARN_LIMIT 8'h57
`define IVLS_CMD_UV_WARN_LIMIT 8'h58
`define IVLS_CMD_UV_FAULT_LIMIT 8'h59
`define IVLS_CMD_UV_FAULT_REACTION 8'h5a

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define IVLS_OV_WARN_RESET 16'hd360
`define IVLS_UV_REACTION_RESET 8'h80
`define IVLS_UV_WARN_NUM 11
`define IVLS_UV_WARN_DEN 10

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define IVLS_EXP_HI 15
`define IVLS_EXP_LO 11
`define IVLS_MANT_HI 10
`define IVLS_BEHAV_HI 7
`define IVLS_BEHAV_LO 6
`define IVLS_RETRY_HI 5
`define IVLS_RETRY_LO 3
`define IVLS_BEHAV_DISABLE 2'h2
`define IVLS_RETRY_NONE 3'h0
`define IVLS_RETRY_FOREVER 3'h7
`define IVLS_SW_NONE_ABOVE 0
`define IVLS_SW_INPUT 13
`define IVLS_SI_OV_WARN 6
`define IVLS_SI_UV_WARN 5
`define IVLS_SI_UV_FAULT 4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define IVLS_CLK_HZ 50000000
`define IVLS_RETRY_TIME_MS 70
`define IVLS_RETRY_CYCLES (`IVLS_RETRY_TIME_MS * (`IVLS_CLK_HZ / 1000))

`endif

// >>> hw/ivls_pkg.sv
// types and linear-format helpers of the supervisor
package ivls_pkg;

  typedef enum logic [3:0] {
    ivls_st_off = 4'h1,
    ivls_st_run = 4'h2,
    ivls_st_latched = 4'h4,
    ivls_st_wait = 4'h8
  } ivls_state_t;

  typedef logic signed [47:0] ivls_fixed_t;

  // linear value to fixed point with 16 fraction bits
  function automatic ivls_fixed_t ivls_decode(input logic [15:0] lin);
    logic signed [4:0] expo;
    logic [5:0] sh;
    ivls_fixed_t mant;
    expo = $signed(lin[15:11]);
    sh = 6'(7'(signed'(expo)) + 7'sd16);
    mant = 48'(signed'(lin[10:0]));
    return mant <<< sh;
  endfunction : ivls_decode

endpackage : ivls_pkg

// >>> hw/ivls_lin_compare.sv
// compares two linear-format values
`timescale 1ns/100ps
module ivls_lin_compare (
  input wire logic [15:0] sample,
  input wire logic [15:0] limit,
  output logic above,
  output logic below
);
  wire ivls_pkg::ivls_fixed_t sample_fix = ivls_pkg::ivls_decode(sample);
  wire ivls_pkg::ivls_fixed_t limit_fix = ivls_pkg::ivls_decode(limit);

  assign above = sample_fix > limit_fix;
  assign below = sample_fix < limit_fix;
endmodule : ivls_lin_compare

// >>> hw/ivls_retry_timer.sv
// one-shot interval timer between restart attempts
`timescale 1ns/100ps
module ivls_retry_timer #(
  parameter int unsigned CYCLES = 3500000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic cancel,
  output logic expired
);
  logic [31:0] count;
  logic running;

  always_ff @(posedge sys_clk) begin
    if (reset || cancel) begin
      count <= 32'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count <= 32'(CYCLES - 1);
      running <= 1'b1;
      expired <= 1'b0;
    end else if (running) begin
      count <= count - 32'h1;
      running <= count != 32'h0;
      expired <= count == 32'h0;
    end else begin
      expired <= 1'b0;
    end
  end
endmodule : ivls_retry_timer

// >>> verification/ivls_supervisor_assertions.sv
// port-level checks of the supervisor
`timescale 1ns/100ps
module ivls_supervisor_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic vin_valid,
  input wire logic run_request,
  input wire logic other_fault,
  input wire logic power_stage_enable,
  input wire logic host_alert_output_n
);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence unmapped_rd;
    reg_rd && reg_addr == 8'h00;
  endsequence
  sequence clear_cmd;
    reg_wr && reg_addr == 8'h03;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  reset_idle_a: assert property (disable iff (1'b0) reset |=>
    host_alert_output_n && !power_stage_enable && reg_rdata == 16'h0000)
    else $error("outputs not idle after reset");
  unmapped_zero_a: assert property (unmapped_rd |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  alert_cause_a: assert property ($fell(host_alert_output_n)
    |-> $past(vin_valid)) else $error("alert without sample");
  alert_clear_a: assert property ($rose(host_alert_output_n)
    |-> $past(clear_cmd)) else $error("alert released without clear");
  enable_cause_a: assert property ($rose(power_stage_enable)
    |-> $past(run_request) && !$past(other_fault))
    else $error("enable rose while off commanded");
  other_off_a: assert property (other_fault [*2] |=> !power_stage_enable)
    else $error("enable kept during other fault");
  cmd_off_a: assert property (!run_request [*2] |=> !power_stage_enable)
    else $error("enable kept while commanded off");
  fault_off_a: assert property ($fell(power_stage_enable)
    |-> $past(vin_valid) || $past(other_fault) || !$past(run_request))
    else $error("enable fell without cause");
endmodule : ivls_supervisor_chk

bind ivls_supervisor ivls_supervisor_chk ivls_supervisor_chk_inst (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vin_valid(vin_valid),
  .run_request(run_request), .other_fault(other_fault),
  .power_stage_enable(power_stage_enable),
  .host_alert_output_n(host_alert_output_n));

// >>> verification/ivls_host_model.sv
// host model driving the register port
`timescale 1ns/100ps
module ivls_host_model (
  input wire logic sys_clk,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd
);
  // ---------------------------------------------------------------
  // accesses
  // ---------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // stale data must not look valid
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : ivls_host_model

// >>> verification/test_input_voltage_limit_supervisor.sv
// self-checking bench of the supervisor
`timescale 1ns/100ps
module test_input_voltage_limit_supervisor;
  localparam int RC = 20;
  localparam logic [15:0] STRAP = 16'hd230;
  logic sys_clk, reset, vin_valid, run_request, other_fault;
  logic reg_wr, reg_rd, power_stage_enable, host_alert_output_n;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, vin_sample, strap, uvw;
  logic [15:0] tv [3] = '{16'hd370, 16'hd250, 16'hd200};
  logic [15:0] ts [3] = '{16'h0040, 16'h0020, 16'h0030};
  logic [7:0] codes [4] = '{8'h00, 8'h40, 8'hc0, 8'h88};
  logic [7:0] rt [2] = '{8'hb8, 8'hbf};
  int failures, cmp_count, n, n0;
  ivls_supervisor #(.RETRY_CYCLES(RC)) ivls_supervisor_inst (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vin_sample(vin_sample),
    .vin_valid(vin_valid), .strap_uv_fault_limit(strap),
    .run_request(run_request), .other_fault(other_fault),
    .power_stage_enable(power_stage_enable),
    .host_alert_output_n(host_alert_output_n));
  ivls_host_model ivls_host_model_inst (.sys_clk(sys_clk),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    ivls_host_model_inst.rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ivls_host_model_inst.wr(a, d);
  endtask : wr
  task automatic smp(input logic [15:0] v);
    @(posedge sys_clk);
    vin_sample <= v;
    vin_valid <= 1'b1;
    @(posedge sys_clk);
    vin_valid <= 1'b0;
    #1;
  endtask : smp
  // bounded wait; a hang ends the run
  task automatic wait_en(input logic v, output int k);
    k = 0;
    while (power_stage_enable !== v) begin
      @(posedge sys_clk);
      #1;
      k++;
      if (k > 200) begin
        failures++;
        give_verdict();
      end
    end
  endtask : wait_en
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    reset = 1'b1;
    vin_valid = 1'b0;
    vin_sample = 16'hd300;
    strap = STRAP;
    run_request = 1'b0;
    other_fault = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    uvw = {STRAP[15:11], 11'(STRAP[10:0] * 11 / 10)};
    rchk(8'h57, 16'hd360);
    rchk(8'h58, uvw);
    rchk(8'h59, STRAP);
    rchk(8'h5a, 16'h0080);
    rchk(8'h00, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(8'h57 + 8'(i), 16'h8421 + 16'(i));
      rchk(8'h57 + 8'(i), 16'h8421 + 16'(i));
    end
    wr(8'h5a, 16'h12a5);
    rchk(8'h5a, 16'h00a5);
    wr(8'h57, 16'hd360);
    wr(8'h58, uvw);
    wr(8'h59, STRAP);
    wr(8'h5a, 16'h0080);
    $display("test registers done");
    run_request <= 1'b1;
    wait_en(1'b1, n);
    for (int i = 0; i < 3; i++) begin
      smp(tv[i]);
      rchk(8'h7c, ts[i]);
      rchk(8'h79, 16'h2001);
      chk({15'h0, host_alert_output_n}, 16'h0000);
      repeat (RC + 5) @(posedge sys_clk);
      chk({15'h0, power_stage_enable}, {15'h0, i < 2});
      wr(8'h03, 16'h0000);
      rchk(8'h7c, 16'h0000);
      chk({15'h0, host_alert_output_n}, 16'h0001);
      wait_en(1'b1, n);
    end
    $display("test thresholds done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h5a, {8'h00, codes[i]});
      smp(16'hd200);
      repeat (RC + 5) @(posedge sys_clk);
      chk({15'h0, power_stage_enable}, {15'h0, i < 3});
      wr(8'h03, 16'h0000);
      wait_en(1'b1, n);
    end
    $display("test unused codes done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h5a, {8'h00, rt[i]});
      smp(16'hd200);
      chk({15'h0, power_stage_enable}, 16'h0000);
      wait_en(1'b1, n);
      chk({15'h0, n + 1 >= RC && n + 1 <= RC + 2}, 16'h0001);
      if (i == 0) begin
        n0 = n;
      end
      chk(16'(n), 16'(n0));
      wr(8'h03, 16'h0000);
    end
    other_fault <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({15'h0, power_stage_enable}, 16'h0000);
    other_fault <= 1'b0;
    wait_en(1'b1, n);
    run_request <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({15'h0, power_stage_enable}, 16'h0000);
    $display("test retry done");
    strap <= 16'hd1f0;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rchk(8'h59, 16'hd1f0);
    rchk(8'h58, 16'hd221);
    rchk(8'h5a, 16'h0080);
    $display("test second reset done");
    give_verdict();
  end
endmodule : test_input_voltage_limit_supervisor
